// *** bench/trp_drive_model.sv ***
`default_nettype none

// ==========================================
// drive input: counts steps per direction
module trp_drive_model (
	input  wire logic        i_clk,     // clock
	input  wire logic        i_clear,   // zero counts
	input  wire logic        i_dual,    // b is reverse pulses
	input  wire logic        i_pulse_a, // step or forward
	input  wire logic        i_pulse_b, // direction or reverse
	output logic      [31:0] o_fwd,     // forward steps
	output logic      [31:0] o_rev,     // reverse steps
	output logic      [31:0] o_period   // cycles between steps
);
	timeunit 1ns;
	timeprecision 1ps;

	logic        a_d;
	logic        b_d;
	logic [31:0] since;

	always @(posedge i_clk) begin
		a_d <= i_pulse_a;
		b_d <= i_pulse_b;
		since <= since + 32'h0000_0001;
		if (i_clear) begin
			o_fwd <= 32'h0000_0000;
			o_rev <= 32'h0000_0000;
			since <= 32'h0000_0000;
		end else if (i_pulse_a && !a_d) begin
			since <= 32'h0000_0001;
			o_period <= since;
			// level on b picks the direction
			if (!i_dual && i_pulse_b)
				o_rev <= o_rev + 32'h0000_0001;
			else
				o_fwd <= o_fwd + 32'h0000_0001;
		end else if (i_dual && i_pulse_b && !b_d) begin
			since <= 32'h0000_0001;
			o_period <= since;
			o_rev <= o_rev + 32'h0000_0001;
		end
	end
endmodule : trp_drive_model

`default_nettype wire

// *** bench/trp_ramp_checker.sv ***
`default_nettype none

module trp_ramp_checker
	import trp_pkg::*;
(
	input wire logic        i_clk,            // clock
	input wire logic        i_resetn,         // reset
	input wire logic        i_ce,             // enable
	input wire logic        i_start,          // start
	input wire logic [3:0]  i_addr,           // index
	input wire logic [15:0] i_wdata,          // data
	input wire logic        i_wr,             // write
	input wire logic        i_rd,             // read
	input wire logic [15:0] o_rdata,          // read data
	input wire logic        o_primary,        // pulses
	input wire logic        o_secondary,      // dir or rev
	input wire logic        o_secondary_used, // owned
	input wire logic        o_active,         // running
	input wire logic        o_complete,       // done
	input wire logic        o_changing        // ramping
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================
	// run, pulse and secondary relations
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	AST_IDLE_QUIET: assert property (!i_start [*3] |-> !o_primary && !o_active)
		else $error("output with start low");
	AST_CLEAR_ON_START: assert property ($rose(i_start) |-> ##[1:2] !o_complete)
		else $error("complete not cleared");
	AST_ACTIVE_NOT_DONE: assert property (o_active |-> !o_complete)
		else $error("active and complete");
	AST_CHANGING_IN_RUN: assert property (o_changing |-> o_active)
		else $error("changing while idle");
	AST_SECONDARY_FREE: assert property (!o_secondary_used |-> !o_secondary)
		else $error("free secondary driven");
	AST_PULSE_IN_RUN: assert property ($rose(o_primary) |-> o_active)
		else $error("pulse outside run");
	// a stop may cut a pulse short, so start low excuses it
	AST_PULSE_WIDTH: assert property ($rose(o_primary) |=> (o_primary || !i_start || !$past(i_start)) [*8])
		else $error("pulse too short");
	AST_REV_LOCKED: assert property (!$fell(o_secondary_used))
		else $error("reversible mode changed");
endmodule : trp_ramp_checker

bind trp_ramp trp_ramp_checker u_chk (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_start(i_start),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_primary(o_primary), .o_secondary(o_secondary), .o_secondary_used(o_secondary_used),
	.o_active(o_active), .o_complete(o_complete), .o_changing(o_changing)
);

`default_nettype wire

// *** bench/trp_ramp_test.sv ***
`default_nettype none

module trp_ramp_test
	import trp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef logic [15:0] trp_cfg_t [8];

	logic        i_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic        i_ce = 1'b1;
	logic        i_start = 1'b0;
	logic [3:0]  i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        m_clear = 1'b1;
	logic        m_dual = 1'b0;
	logic [15:0] o_rdata, rv;
	logic        o_primary, o_secondary, o_secondary_used, o_active, o_complete, o_changing;
	logic        chg_early, chg_mid, chg_end, sec_mid;
	logic [31:0] m_fwd, m_rev, m_per, per_mid;
	int          n_fail = 0;
	int          num_checks = 0;
	trp_cfg_t    good = '{16'h0002, 16'h0064, 16'h0032, 16'h000A, 16'h0000, 16'h0000, 16'h0000, 16'h0008};
	// index, value, index, value, expected error code
	logic [15:0] tab [14][5] = '{
		'{16'h0000, 16'h0004, 16'h0000, 16'h0004, 16'h0001}, '{16'h0002, 16'h0065, 16'h0002, 16'h0065, 16'h0002},
		'{16'h0002, 16'h0000, 16'h0002, 16'h0000, 16'h0002}, '{16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0004},
		'{16'h0003, 16'h0065, 16'h0003, 16'h0065, 16'h0005}, '{16'h0004, 16'h0003, 16'h0004, 16'h0003, 16'h0006},
		'{16'h0005, 16'h0002, 16'h0005, 16'h0002, 16'h0007}, '{16'h0007, 16'h0000, 16'h0007, 16'h0000, 16'h0003},
		'{16'h0006, 16'h05F5, 16'h0007, 16'hE101, 16'h0003}, '{16'h0000, 16'h0003, 16'h0002, 16'h0013, 16'h0002},
		'{16'h0000, 16'h0003, 16'h0001, 16'h2711, 16'h0004}, '{16'h0000, 16'h0003, 16'h0003, 16'h0009, 16'h0005},
		'{16'h0002, 16'h0064, 16'h0002, 16'h0064, 16'h0009}, '{16'h0003, 16'h003C, 16'h0003, 16'h003C, 16'h000A}};

	always #5 i_clk = ~i_clk;

	trp_ramp #(.P_DUAL_OK(1'b1), .P_TICK_CYCLES(100)) DUT (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_start(i_start),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_primary(o_primary), .o_secondary(o_secondary), .o_secondary_used(o_secondary_used),
		.o_active(o_active), .o_complete(o_complete), .o_changing(o_changing));

	trp_drive_model u_drive (
		.i_clk(i_clk), .i_clear(m_clear), .i_dual(m_dual), .i_pulse_a(o_primary),
		.i_pulse_b(o_secondary), .o_fwd(m_fwd), .o_rev(m_rev), .o_period(m_per));

	// ==========================================
	// bus and compare tasks
	task automatic wrap_up;
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// steady rate may be off by up to five percent
	task automatic cmp_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		num_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, lo);
		end
	endtask : cmp_rng

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
		@(posedge i_clk);
	endtask : rd

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		cmp(32'(d), 32'(exp));
	endtask : rd_chk

	task automatic do_reset;
		i_resetn <= 1'b0;
		repeat (6) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
	endtask : do_reset

	task automatic cfg(input trp_cfg_t w);
		for (int i = 0; i < 8; i++)
			wr(4'(i), w[i]);
		for (int i = 0; i < 8; i++)
			rd_chk(4'(i), w[i]);
	endtask : cfg

	task automatic go(input int lim);
		m_clear <= 1'b1;
		i_start <= 1'b1;
		@(posedge i_clk);
		m_clear <= 1'b0;
		for (int k = 0; k < lim; k++) begin
			@(posedge i_clk);
			if (k == 20)
				chg_early = o_changing;
			if (m_fwd + m_rev == 32'h0000_0003) begin
				chg_mid = o_changing;
				sec_mid = o_secondary;
				per_mid = m_per;
			end
			// last value seen before the run ends
			if (o_complete !== 1'b1)
				chg_end = o_changing;
			if (k > 4 && o_complete === 1'b1)
				break;
		end
		i_start <= 1'b0;
		@(posedge i_clk);
	endtask : go

	// ==========================================
	// scenarios
	initial begin
		#950_000;
		n_fail++;
		wrap_up();
	end

	initial begin
		do_reset();
		for (int i = 0; i < 13; i++)
			rd_chk(4'(i), 16'h0000);
		wr(REG_COUNT_LO, 16'h1234);
		rd_chk(REG_COUNT_LO, 16'h0000);
		m_dual <= 1'b1;
		cfg('{16'h0002, 16'h0064, 16'h0032, 16'h000A, 16'h0002, 16'h0001, 16'h0000, 16'h0008});
		go(100000);
		cmp(m_rev, 32'h0000_0008);
		cmp(m_fwd, 32'h0000_0000);
		cmp(32'({chg_early, chg_mid, chg_end}), 32'h0000_0004);
		cmp_rng(per_mid, 32'h0000_03B6, 32'h0000_041A);
		rd_chk(REG_COUNT_HI, 16'h0000);
		rd_chk(REG_COUNT_LO, 16'h0008);
		rd_chk(REG_STATUS, 16'h0002);
		wr(REG_REV, 16'h0000);
		go(100000);
		cmp(m_rev, 32'h0000_0008);
		cmp(32'(o_secondary_used), 32'h0000_0001);
		do_reset();
		m_dual <= 1'b0;
		cfg('{16'h0001, 16'h0064, 16'h0063, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0004});
		go(100000);
		cmp(m_rev, 32'h0000_0004);
		cmp(32'(sec_mid), 32'h0000_0001);
		cmp_rng(per_mid, 32'h0000_251C, 32'h0000_2904);
		wr(REG_MODE, 16'h0002);
		wr(REG_DIR, 16'h0000);
		// slow ramp from half range, so pulses fall inside both ramps
		wr(REG_INITIAL, 16'h0032);
		go(100000);
		cmp(m_fwd, 32'h0000_0004);
		cmp(32'(chg_end), 32'h0000_0001);
		cmp(32'(sec_mid), 32'h0000_0000);
		do_reset();
		cfg('{16'h0003, 16'h2710, 16'h2706, 16'h000F, 16'h0000, 16'h0000, 16'h0000, 16'h0008});
		go(100000);
		cmp(m_fwd, 32'h0000_0008);
		cmp_rng(per_mid, 32'h0000_03B6, 32'h0000_041A);
		cmp(32'({o_secondary_used, sec_mid}), 32'h0000_0000);
		for (int i = 0; i < 14; i++) begin
			cfg(good);
			wr(tab[i][0][3:0], tab[i][1]);
			wr(tab[i][2][3:0], tab[i][3]);
			go(6);
			rd_chk(REG_ERROR, tab[i][4]);
		end
		cfg(good);
		wr(REG_TOTAL_HI, 16'h05F5);
		wr(REG_TOTAL_LO, 16'hE100);
		m_clear <= 1'b1;
		i_start <= 1'b1;
		@(posedge i_clk);
		m_clear <= 1'b0;
		for (int k = 0; k < 20000 && m_fwd !== 32'h0000_0003; k++)
			@(posedge i_clk);
		i_start <= 1'b0;
		repeat (3) @(posedge i_clk);
		cmp(32'({o_active, o_complete}), 32'h0000_0001);
		rd_chk(REG_ERROR, 16'h0000);
		rd(REG_COUNT_LO, rv);
		// quiet window, long enough for two steady pulses
		repeat (2000) @(posedge i_clk);
		cmp(m_fwd, 32'h0000_0003);
		rd_chk(REG_COUNT_LO, rv);
		// enable low must freeze the register file as well
		i_ce <= 1'b0;
		wr(REG_DIR, 16'h0001);
		i_ce <= 1'b1;
		rd_chk(REG_DIR, 16'h0000);
		wr(REG_TOTAL_HI, 16'h0000);
		wr(REG_TOTAL_LO, 16'h0002);
		go(100000);
		cmp(m_fwd, 32'h0000_0002);
		rd_chk(REG_COUNT_LO, 16'h0002);
		wrap_up();
	end
endmodule : trp_ramp_test

`default_nettype wire

// *** logic/trp_div.sv ***
`default_nettype none

module trp_div #(
	parameter int unsigned P_NW = 20,
	parameter int unsigned P_DW = 16
) (
	input  wire logic            i_clk,    // system clock
	input  wire logic            i_resetn, // sync reset, active low
	input  wire logic            i_ce,     // clock enable
	input  wire logic            i_start,  // one-cycle start
	input  wire logic [P_NW-1:0] i_num,    // dividend
	input  wire logic [P_DW-1:0] i_den,    // divisor, nonzero
	output logic      [P_NW-1:0] o_quot,   // quotient
	output logic                 o_done    // one cycle when quotient valid
);

	localparam int unsigned CW = $clog2(P_NW + 1);

	typedef struct packed {
		logic            busy;
		logic            done;
		logic [P_NW-1:0] q;
		logic [P_DW:0]   rem;
		logic [CW-1:0]   cnt;
	} trp_div_t;

	trp_div_t r;
	trp_div_t next_r;
	logic [P_DW:0] sh;

	// ==========================================
	// restoring division, one quotient bit per cycle
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		sh = {r.rem[P_DW-1:0], r.q[P_NW-1]};
		if (i_start) begin
			next_r.busy = 1'b1;
			next_r.q = i_num;
			next_r.rem = '0;
			next_r.cnt = CW'(P_NW);
		end else if (r.busy) begin
			next_r.q = {r.q[P_NW-2:0], 1'b0};
			if (sh >= {1'b0, i_den}) begin
				sh = sh - {1'b0, i_den};
				next_r.q[0] = 1'b1;
			end
			next_r.rem = sh;
			next_r.cnt = r.cnt - CW'(1);
			if (r.cnt == CW'(1)) begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			r <= '0;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign o_quot = r.q;
	assign o_done = r.done;

endmodule : trp_div

`default_nettype wire

// *** logic/trp_nco.sv ***
`default_nettype none

module trp_nco
	import trp_pkg::*;
#(
	parameter int unsigned P_FW = 20
) (
	input  wire logic            i_clk,    // system clock
	input  wire logic            i_resetn, // sync reset, active low
	input  wire logic            i_ce,     // clock enable
	input  wire logic            i_run,    // generate while high
	input  wire logic [P_FW-1:0] i_freq,   // frequency in Hz
	output logic                 o_level,  // pulse level
	output logic                 o_fall    // one cycle at end of each pulse, none when i_run drops during a pulse
);

	localparam logic [31:0] LIM  = 32'(CLK_HZ);
	localparam logic [31:0] HALF = 32'(CLK_HZ / 2);

	typedef struct packed {
		logic [31:0] acc;
		logic        level;
		logic        fall;
	} trp_nco_t;

	trp_nco_t r;
	trp_nco_t next_r;
	logic [31:0] sum;

	// ==========================================
	// phase accumulator, first half of each period high
	always_comb begin
		next_r = r;
		next_r.fall = 1'b0;
		sum = r.acc + 32'(i_freq);
		if (sum >= LIM) begin
			sum = sum - LIM;
		end
		if (!i_run) begin
			next_r.acc = 32'h0000_0000;
			next_r.level = 1'b0;
		end else begin
			next_r.acc = sum;
			next_r.level = (sum < HALF);
			next_r.fall = r.level && !(sum < HALF);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			r <= '0;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign o_level = r.level;
	assign o_fall = r.fall;

endmodule : trp_nco

`default_nettype wire

// *** logic/trp_pkg.sv ***
`default_nettype none

package trp_pkg;

	// ==========================================
	// timing
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned RAMP_TICK_MS  = 10;
	localparam int unsigned RAMP_TICK_CYC = RAMP_TICK_MS * (CLK_HZ / 1000);

	// ==========================================
	// register indices
	localparam logic [3:0] REG_MODE     = 4'h0;
	localparam logic [3:0] REG_STEADY   = 4'h1;
	localparam logic [3:0] REG_INITIAL  = 4'h2;
	localparam logic [3:0] REG_RATE     = 4'h3;
	localparam logic [3:0] REG_REV      = 4'h4;
	localparam logic [3:0] REG_DIR      = 4'h5;
	localparam logic [3:0] REG_TOTAL_HI = 4'h6;
	localparam logic [3:0] REG_TOTAL_LO = 4'h7;
	localparam logic [3:0] REG_COUNT_HI = 4'h8;
	localparam logic [3:0] REG_COUNT_LO = 4'h9;
	localparam logic [3:0] REG_ERROR    = 4'hA;
	localparam logic [3:0] REG_STATUS   = 4'hB;

	// status word bit positions
	localparam int unsigned STAT_ACTIVE   = 0;
	localparam int unsigned STAT_COMPLETE = 1;
	localparam int unsigned STAT_CHANGING = 2;

	// ==========================================
	// value ranges and scaling
	localparam logic [15:0] MODE_WIDE     = 16'h0003;
	localparam logic [19:0] UNIT_MODE0    = 20'h0_000A;
	localparam logic [19:0] UNIT_MODE1    = 20'h0_0064;
	localparam logic [19:0] UNIT_MODE2    = 20'h0_03E8;
	localparam logic [19:0] UNIT_MODE3    = 20'h0_000A;
	localparam logic [15:0] PCT_MIN       = 16'h0001;
	localparam logic [15:0] PCT_MAX       = 16'h0064;
	localparam logic [15:0] M3_FREQ_MIN   = 16'h0014;
	localparam logic [15:0] M3_FREQ_MAX   = 16'h2710;
	localparam logic [15:0] M3_TIME_MIN   = 16'h000A;
	localparam logic [15:0] M3_TIME_MAX   = 16'h2710;
	localparam logic [15:0] M3_TIME_STEP  = 16'h000A;
	localparam logic [31:0] TOTAL_MIN     = 32'h0000_0001;
	localparam logic [31:0] TOTAL_MAX     = 32'h05F5_E100;
	localparam logic [1:0]  REV_OFF       = 2'h0;
	localparam logic [1:0]  REV_DIR_LEVEL = 2'h1;
	localparam logic [1:0]  REV_DUAL      = 2'h2;

	// ==========================================
	// error codes
	localparam logic [15:0] ERR_NONE      = 16'h0000;
	localparam logic [15:0] ERR_MODE      = 16'h0001;
	localparam logic [15:0] ERR_INITIAL   = 16'h0002;
	localparam logic [15:0] ERR_TOTAL     = 16'h0003;
	localparam logic [15:0] ERR_STEADY    = 16'h0004;
	localparam logic [15:0] ERR_RATE      = 16'h0005;
	localparam logic [15:0] ERR_REV       = 16'h0006;
	localparam logic [15:0] ERR_DIR       = 16'h0007;
	localparam logic [15:0] ERR_ORDER     = 16'h0009;
	localparam logic [15:0] ERR_RATE_SPAN = 16'h000A;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_DIV,
		ST_ACCEL,
		ST_STEADY,
		ST_DECEL
	} trp_state_t;

endpackage : trp_pkg

`default_nettype wire

// *** logic/trp_ramp.sv ***
`default_nettype none

module trp_ramp
	import trp_pkg::*;
#(
	parameter bit          P_DUAL_OK    = 1'b1,
	parameter int unsigned P_TICK_CYCLES = RAMP_TICK_CYC
) (
	input  wire logic        i_clk,            // 100 MHz clock
	input  wire logic        i_resetn,         // sync reset, active low
	input  wire logic        i_ce,             // clock enable, freezes all state
	input  wire logic        i_start,          // start input level
	input  wire logic [3:0]  i_addr,           // register index
	input  wire logic [15:0] i_wdata,          // write data
	input  wire logic        i_wr,             // write strobe
	input  wire logic        i_rd,             // read strobe
	output logic      [15:0] o_rdata,          // read data, cycle after read
	output logic             o_primary,        // primary pulse output
	output logic             o_secondary,      // direction or reverse pulses
	output logic             o_secondary_used, // secondary owned by this block
	output logic             o_active,         // pulses being generated
	output logic             o_complete,       // run finished or stopped
	output logic             o_changing        // frequency ramping
);

	typedef struct packed {
		trp_state_t       state;
		logic [7:0][15:0] prm;
		logic [1:0]       rev;
		logic             rev_locked;
		logic             dir;
		logic [31:0]      total;
		logic [31:0]      count;
		logic [31:0]      accel_cnt;
		logic [19:0]      freq;
		logic [19:0]      f_init;
		logic [19:0]      f_st;
		logic [19:0]      step;
		logic [31:0]      tick;
		logic             start_d;
		logic             div_go;
		logic [15:0]      err;
		logic [15:0]      rdata;
		logic             primary;
		logic             secondary;
		logic             sec_used;
		logic             active;
		logic             complete;
		logic             changing;
	} trp_ramp_t;

	localparam logic [31:0] TICK_LAST = 32'(P_TICK_CYCLES - 1);

	trp_ramp_t r;
	trp_ramp_t next_r;

	logic        nco_run;
	logic        nco_level;
	logic        nco_fall;
	logic [19:0] div_quot;
	logic        div_done;
	logic [15:0] rate_tenths;

	// ==========================================
	// word decode and checks
	logic [15:0] w_mode;
	logic [15:0] w_st;
	logic [15:0] w_init;
	logic [15:0] w_rate;
	logic [15:0] w_rev;
	logic [15:0] w_dir;
	logic [31:0] w_total;
	logic        is_m3;
	logic [19:0] unit;
	logic [35:0] f_st_w;
	logic [35:0] f_init_w;
	logic [35:0] step_w;
	logic [15:0] rev_max;
	logic [15:0] err_w;
	logic [31:0] remain;
	logic        running;
	logic        pulse;
	logic [20:0] fsum;

	always_comb begin
		w_mode  = r.prm[REG_MODE[2:0]];
		w_st    = r.prm[REG_STEADY[2:0]];
		w_init  = r.prm[REG_INITIAL[2:0]];
		w_rate  = r.prm[REG_RATE[2:0]];
		w_rev   = r.prm[REG_REV[2:0]];
		w_dir   = r.prm[REG_DIR[2:0]];
		w_total = {r.prm[REG_TOTAL_HI[2:0]], r.prm[REG_TOTAL_LO[2:0]]};
		is_m3   = (w_mode == MODE_WIDE);
		unique case (w_mode[1:0])
			2'd0: unit = UNIT_MODE0;
			2'd1: unit = UNIT_MODE1;
			2'd2: unit = UNIT_MODE2;
			2'd3: unit = UNIT_MODE3;
		endcase
		f_st_w   = 36'(w_st) * 36'(unit);
		f_init_w = 36'(w_init) * 36'(unit);
		step_w   = 36'(w_rate) * 36'(unit);
		rev_max  = P_DUAL_OK ? 16'(REV_DUAL) : 16'(REV_DIR_LEVEL);
		// first failing word wins, in code order
		if (w_mode > MODE_WIDE) begin
			err_w = ERR_MODE;
		end else if (is_m3 ? (w_init < M3_FREQ_MIN || w_init > M3_FREQ_MAX)
				: (w_init < PCT_MIN || w_init > PCT_MAX)) begin
			err_w = ERR_INITIAL;
		end else if (w_total < TOTAL_MIN || w_total > TOTAL_MAX) begin
			err_w = ERR_TOTAL;
		end else if (is_m3 ? (w_st < M3_FREQ_MIN || w_st > M3_FREQ_MAX)
				: (w_st < PCT_MIN || w_st > PCT_MAX)) begin
			err_w = ERR_STEADY;
		end else if (is_m3 ? (w_rate < M3_TIME_MIN || w_rate > M3_TIME_MAX)
				: (w_rate < PCT_MIN || w_rate > PCT_MAX)) begin
			err_w = ERR_RATE;
		end else if (w_rev > rev_max) begin
			err_w = ERR_REV;
		end else if (w_dir > 16'h0001) begin
			err_w = ERR_DIR;
		end else if (w_init >= w_st) begin
			err_w = ERR_ORDER;
		end else if (!is_m3 && f_st_w - f_init_w < step_w) begin
			err_w = ERR_RATE_SPAN;
		end else begin
			err_w = ERR_NONE;
		end
	end

	// units digit of the change time is dropped
	assign rate_tenths = w_rate / M3_TIME_STEP;

	// ==========================================
	// sequencer
	always_comb begin
		next_r = r;
		next_r.div_go = 1'b0;
		next_r.start_d = i_start;
		running = (r.state == ST_ACCEL) || (r.state == ST_STEADY) || (r.state == ST_DECEL);
		remain = 32'h0000_0000;
		fsum = 21'(r.freq) + 21'(r.step);

		if (i_wr && i_addr <= REG_TOTAL_LO) begin
			next_r.prm[i_addr[2:0]] = i_wdata;
		end

		if (running) begin
			next_r.tick = (r.tick == TICK_LAST) ? 32'h0000_0000 : r.tick + 32'h0000_0001;
		end else begin
			next_r.tick = 32'h0000_0000;
		end

		unique case (r.state)
			ST_IDLE: begin
				if (i_start && !r.start_d) begin
					next_r.state = ST_CHECK;
					next_r.complete = 1'b0;
				end
			end
			ST_CHECK: begin
				next_r.err = err_w;
				if (!r.rev_locked) begin
					next_r.rev = w_rev[1:0];
					next_r.rev_locked = 1'b1;
				end
				if (err_w != ERR_NONE) begin
					next_r.state = ST_IDLE;
				end else begin
					next_r.dir = w_dir[0];
					next_r.total = w_total;
					next_r.count = 32'h0000_0000;
					next_r.accel_cnt = 32'h0000_0000;
					next_r.f_init = f_init_w[19:0];
					next_r.f_st = f_st_w[19:0];
					next_r.freq = f_init_w[19:0];
					next_r.active = 1'b1;
					if (is_m3) begin
						next_r.state = ST_DIV;
						next_r.div_go = 1'b1;
					end else begin
						next_r.step = step_w[19:0];
						next_r.state = ST_ACCEL;
					end
				end
			end
			ST_DIV: begin
				if (div_done) begin
					next_r.step = (div_quot == 20'h0_0000) ? 20'h0_0001 : div_quot;
					next_r.state = ST_ACCEL;
				end
			end
			ST_ACCEL: begin
				if (r.tick == TICK_LAST) begin
					if (fsum >= 21'(r.f_st)) begin
						next_r.freq = r.f_st;
						next_r.state = ST_STEADY;
					end else begin
						next_r.freq = fsum[19:0];
					end
				end
			end
			ST_STEADY: begin
			end
			ST_DECEL: begin
				if (r.tick == TICK_LAST) begin
					if (21'(r.freq) <= 21'(r.f_init) + 21'(r.step)) begin
						next_r.freq = r.f_init;
					end else begin
						next_r.freq = r.freq - r.step;
					end
				end
			end
		endcase

		if (running) begin
			if (nco_fall) begin
				next_r.count = r.count + 32'h0000_0001;
				if (r.state == ST_ACCEL) begin
					next_r.accel_cnt = r.accel_cnt + 32'h0000_0001;
				end
			end
			remain = r.total - next_r.count;
			if ((next_r.state == ST_ACCEL || next_r.state == ST_STEADY)
					&& remain <= next_r.accel_cnt) begin
				next_r.state = ST_DECEL;
			end
			if (next_r.count == r.total) begin
				next_r.state = ST_IDLE;
				next_r.active = 1'b0;
				next_r.complete = 1'b1;
			end
		end

		if (!i_start && r.state != ST_IDLE) begin
			next_r.state = ST_IDLE;
			next_r.active = 1'b0;
			next_r.complete = r.active;
		end
		next_r.changing = next_r.active && (next_r.state == ST_ACCEL || next_r.state == ST_DECEL);

		// ==========================================
		// output steering
		pulse = running && nco_level && next_r.state != ST_IDLE;
		unique case (r.rev)
			REV_DIR_LEVEL: begin
				next_r.primary = pulse;
				next_r.secondary = r.dir;
				next_r.sec_used = 1'b1;
			end
			REV_DUAL: begin
				next_r.primary = pulse && !r.dir;
				next_r.secondary = pulse && r.dir;
				next_r.sec_used = 1'b1;
			end
			default: begin
				next_r.primary = pulse;
				next_r.secondary = 1'b0;
				next_r.sec_used = 1'b0;
			end
		endcase

		// ==========================================
		// register reads
		next_r.rdata = 16'h0000;
		if (i_rd) begin
			if (i_addr <= REG_TOTAL_LO) begin
				next_r.rdata = r.prm[i_addr[2:0]];
			end else if (i_addr == REG_COUNT_HI) begin
				next_r.rdata = r.count[31:16];
			end else if (i_addr == REG_COUNT_LO) begin
				next_r.rdata = r.count[15:0];
			end else if (i_addr == REG_ERROR) begin
				next_r.rdata = r.err;
			end else if (i_addr == REG_STATUS) begin
				next_r.rdata[STAT_ACTIVE] = r.active;
				next_r.rdata[STAT_COMPLETE] = r.complete;
				next_r.rdata[STAT_CHANGING] = r.changing;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			r <= '0;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	// ==========================================
	// pulse synthesis and step division
	assign nco_run = (r.state == ST_ACCEL) || (r.state == ST_STEADY) || (r.state == ST_DECEL);

	trp_nco #(
		.P_FW (20)
	) u_nco (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_ce     (i_ce),
		.i_run    (nco_run),
		.i_freq   (r.freq),
		.o_level  (nco_level),
		.o_fall   (nco_fall)
	);

	// mode 3 step is frequency span over number of ticks
	trp_div #(
		.P_NW (20),
		.P_DW (16)
	) u_div (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_ce     (i_ce),
		.i_start  (r.div_go),
		.i_num    (r.f_st - r.f_init),
		.i_den    (rate_tenths),
		.o_quot   (div_quot),
		.o_done   (div_done)
	);

	assign o_rdata          = r.rdata;
	assign o_primary        = r.primary;
	assign o_secondary      = r.secondary;
	assign o_secondary_used = r.sec_used;
	assign o_active         = r.active;
	assign o_complete       = r.complete;
	assign o_changing       = r.changing;

endmodule : trp_ramp

`default_nettype wire
